/* hw/twm_master_tx.sv */
// two-wire master transmitter with register port and open-drain bus pins
// Behaviour
// - four modes; this block does master transmit
// - read/nack high, write/ack low, 8-bit bytes
// - status held while flag set; bus suspended
// - address direction bit picks master mode
// - start request waits for free bus
// - start sent sets flag, status 08h
// - read address in 10h enters receive mode
// - write address outcome gives 18h/20h/38h
// - data write with flag low discarded
// - stop requested by stop bit, flag cleared
// - repeated start gives status 10h
// - 18h address acked, 20h not acked
// - 28h data acked, 30h not acked
// - plain flag clear sends loaded byte
// - start only gives repeated start
// - stop only sends stop, clears stop bit
// - start and stop: stop then start
// - 38h lost; bus released at once, clear goes idle
// - 38h with start waits, then starts
// - clock line held low while flag set, except in 38h
// - no flag after a stop
`timescale 1ns/10ps
module twm_master_tx (
   input  wire logic              ref_clk,      // 25 MHz system clock
   input  wire logic              sys_rst,      // async reset, active high
   input  wire twm_pkg::twm_addr_t reg_addr,    // register index
   input  wire twm_pkg::twm_byte_t reg_wdata,   // write data
   input  wire logic              reg_wr,       // write strobe
   input  wire logic              reg_rd,       // read strobe
   output twm_pkg::twm_byte_t     reg_rdata,    // read data, cycle after strobe
   input  wire logic              scl_in,       // clock line level
   output logic                   scl_out,      // clock line drive value
   output logic                   scl_oe,       // clock line pulled low
   input  wire logic              sda_in,       // data line level
   output logic                   sda_out,      // data line drive value
   output logic                   sda_oe,       // data line pulled low
   output logic                   master_transmit_mode, // address sent with write
   output logic                   master_receive_mode,  // address sent with read
   output logic                   step_done_flag        // copy of the flag bit
);
   import twm_pkg::*;

   twm_ctrl_s  ctrl_q;                          // control register
   twm_byte_t  data_q;                          // data register
   twm_byte_t  status_q;                        // last status code
   twm_byte_t  rate_q;                          // divider reload
   twm_byte_t  div_q;                           // divider count
   twm_byte_t  rdata_q;                         // read data register
   twm_state_e state_q, state_d;                // sequencer
   logic       scl_low_q, scl_low_d;            // pull clock low
   logic       sda_low_q, sda_low_d;            // pull data low
   twm_byte_t  shift_q, shift_d;                // outgoing byte
   logic [3:0] bits_q, bits_d;                  // bits sent
   logic       rs_q, rs_d;                      // start is a repeat
   logic       addr_q, addr_d;                  // byte is an address
   logic       mr_q, mr_d;                      // receive mode
   logic       mt_q, mt_d;                      // transmit mode
   logic       flag_set;                        // hardware sets flag
   twm_byte_t  code_d;                          // code to load
   logic       sto_clr;                         // hardware clears stop bit
   logic       code_ld;                         // ack outcome parked before flag
   logic       scl_m, scl_s, scl_p;             // clock line sync
   logic       sda_m, sda_s, sda_p;             // data line sync
   logic       busy_q;                          // bus owned by anyone

   // decode
   wire tick      = (div_q == 8'h00);           // quarter-bit enable
   wire wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL);
   wire wr_data   = reg_wr && (reg_addr == ADDR_DATA);
   wire wr_stat   = reg_wr && (reg_addr == ADDR_STAT);
   wire wr_rate   = reg_wr && (reg_addr == ADDR_RATE);
   wire start_see = scl_s && scl_p && sda_p && !sda_s; // falling data, clock high
   wire stop_see  = scl_s && scl_p && !sda_p && sda_s; // rising data, clock high
   wire addr_ph   = (status_q == ST_START) || (status_q == ST_RSTART);
   wire ack_seen  = !sda_s;                      // low means acknowledge
   wire bit_done  = (state_q == S_BHIGH) && tick && scl_s;
   wire arb_lost  = bit_done && (bits_q != BYTE_BITS) && !sda_low_q && !sda_s;
   wire twm_byte_t ctrl_rd = {1'b0, ctrl_q.en, ctrl_q.start_request, ctrl_q.stop_request,
                              ctrl_q.flag, ctrl_q.ack, 2'b00};
   // status reads as no-code while the flag is low
   wire twm_byte_t stat_rd = ctrl_q.flag ? status_q : ST_NONE;
   wire twm_byte_t rd_mux  = (reg_addr == ADDR_CTRL) ? ctrl_rd :
                             (reg_addr == ADDR_DATA) ? data_q  :
                             (reg_addr == ADDR_STAT) ? stat_rd : rate_q;

   // outputs; open drain, so the drive value is always low
   assign scl_out              = 1'b0;
   assign sda_out              = 1'b0;
   assign scl_oe               = scl_low_q;
   assign sda_oe               = sda_low_q;
   assign reg_rdata            = rdata_q;
   assign master_transmit_mode = mt_q;
   assign master_receive_mode  = mr_q;
   assign step_done_flag       = ctrl_q.flag;

   // two-stage sync plus a history stage for edge finding
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {scl_m, scl_s, scl_p} <= 3'h7;
         {sda_m, sda_s, sda_p} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
         {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
      end
   end

   // bus busy between any start and the next stop
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)        busy_q <= 1'b0;
      else if (start_see) busy_q <= 1'b1;
      else if (stop_see)  busy_q <= 1'b0;
   end

   // quarter-bit divider; stretching is absorbed by waiting on the line
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)   div_q <= RST_RATE;
      else if (tick) div_q <= rate_q;
      else           div_q <= div_q - 8'h01;
   end

   // control register; a hardware set of the flag beats a software clear
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= RST_CTRL;
      end else begin
         if (wr_ctrl) begin
            ctrl_q.en  <= reg_wdata[CB_EN];
            ctrl_q.start_request <= reg_wdata[CB_STA];
            ctrl_q.ack <= reg_wdata[CB_ACK];        // no steering effect
         end
         if (wr_ctrl)      ctrl_q.stop_request <= reg_wdata[CB_STO];
         else if (sto_clr) ctrl_q.stop_request <= 1'b0;
         if (flag_set)     ctrl_q.flag <= 1'b1;
         else if (wr_ctrl && !reg_wdata[CB_FLAG]) ctrl_q.flag <= 1'b0;
      end
   end

   // data register only accepts writes while the flag is up
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)                    data_q <= RST_DATA;
      else if (wr_data && ctrl_q.flag) data_q <= reg_wdata;
   end

   // status code loads with the flag, or earlier when an ack outcome is parked; writes are ignored
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)       status_q <= ST_NONE;
      else if (flag_set || code_ld) status_q <= code_d;
   end

   // divider reload and read data
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rate_q  <= RST_RATE;
         rdata_q <= 8'h00;
      end else begin
         if (wr_rate) rate_q <= reg_wdata;
         if (reg_rd)  rdata_q <= rd_mux;
      end
   end

   // sequencer registers
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q   <= S_IDLE;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
         shift_q   <= 8'h00;
         bits_q    <= 4'h0;
         {rs_q, addr_q, mr_q, mt_q} <= 4'h0;
      end else begin
         state_q   <= state_d;
         scl_low_q <= scl_low_d;
         sda_low_q <= sda_low_d;
         shift_q   <= shift_d;
         bits_q    <= bits_d;
         {rs_q, addr_q, mr_q, mt_q} <= {rs_d, addr_d, mr_d, mt_d};
      end
   end

   // sequencer next state; only enable, start, stop and flag steer it
   always_comb begin
      state_d   = state_q;
      scl_low_d = scl_low_q;
      sda_low_d = sda_low_q;
      shift_d   = shift_q;
      bits_d    = bits_q;
      rs_d      = rs_q;
      addr_d    = addr_q;
      mr_d      = mr_q;
      mt_d      = mt_q;
      flag_set  = 1'b0;
      code_d    = status_q;
      sto_clr   = 1'b0;
      code_ld   = 1'b0;
      if (!ctrl_q.en) begin
         // disabled: let go of both lines at once
         state_d   = S_IDLE;
         scl_low_d = 1'b0;
         sda_low_d = 1'b0;
         mr_d      = 1'b0;
         mt_d      = 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               scl_low_d = 1'b0;
               sda_low_d = 1'b0;
               mr_d      = 1'b0;
               mt_d      = 1'b0;
               if (ctrl_q.start_request && !ctrl_q.flag) state_d = S_WFREE;
               else if (ctrl_q.stop_request && !ctrl_q.flag) sto_clr = 1'b1;
            end
            S_WFREE: begin
               // no start while someone else holds the bus
               if (tick && !busy_q && scl_s && sda_s) begin
                  sda_low_d = 1'b1;
                  rs_d      = 1'b0;
                  state_d   = S_ST1;
               end
            end
            S_ST1: begin
               if (tick) begin
                  scl_low_d = 1'b1;
                  state_d   = S_ST2;
               end
            end
            S_ST2: begin
               if (tick) begin
                  flag_set = 1'b1;
                  code_d   = rs_q ? ST_RSTART : ST_START;
                  state_d  = S_HOLD;
               end
            end
            S_HOLD: begin
               // clock stays low until software clears the flag
               scl_low_d = 1'b1;
               if (!ctrl_q.flag) begin
                  if (addr_ph) begin
                     // address byte; direction bit picks the mode
                     shift_d = data_q;
                     mr_d    = data_q[0];
                     mt_d    = !data_q[0];
                     addr_d  = 1'b1;
                     bits_d  = 4'h0;
                     state_d = S_BLOW;
                  end else if (ctrl_q.stop_request) begin
                     state_d = S_SP1;
                  end else if (ctrl_q.start_request) begin
                     state_d = S_RS1;
                  end else if (mr_q) begin
                     // receive data phase belongs to the receiver block
                     state_d = S_IDLE;
                  end else begin
                     shift_d = data_q;
                     addr_d  = 1'b0;
                     bits_d  = 4'h0;
                     state_d = S_BLOW;
                  end
               end
            end
            S_BLOW: begin
               // data changes only while the clock is low
               if (tick) begin
                  sda_low_d = (bits_q == BYTE_BITS) ? 1'b0 : !shift_q[7];
                  state_d   = S_BSET;
               end
            end
            S_BSET: begin
               if (tick) begin
                  scl_low_d = 1'b0;
                  state_d   = S_BHIGH;
               end
            end
            S_BHIGH: begin
               // a slave holding the clock low delays this sample
               if (arb_lost) begin
                  scl_low_d = 1'b0;
                  sda_low_d = 1'b0;
                  flag_set  = 1'b1;
                  code_d    = ST_ARB;
                  mr_d      = 1'b0;
                  mt_d      = 1'b0;
                  state_d   = S_LOST;
               end else if (bit_done) begin
                  scl_low_d = 1'b1;
                  if (bits_q == BYTE_BITS) begin
                     if (!addr_q)   code_d = ack_seen ? ST_D_ACK : ST_D_NACK;
                     else if (mr_q) code_d = ack_seen ? ST_AR_ACK : ST_AR_NACK;
                     else           code_d = ack_seen ? ST_AW_ACK : ST_AW_NACK;
                     // park the code now; the ack level is gone by the flag tick
                     code_ld = 1'b1;
                     state_d = S_AEND;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     bits_d  = bits_q + 4'h1;
                     state_d = S_BLOW;
                  end
               end
            end
            S_AEND: begin
               if (tick) begin
                  flag_set = 1'b1;
                  state_d  = S_HOLD;
               end
            end
            S_SP1: begin
               if (tick) begin
                  sda_low_d = 1'b1;
                  state_d   = S_SP2;
               end
            end
            S_SP2: begin
               if (tick) begin
                  scl_low_d = 1'b0;
                  state_d   = S_SP3;
               end
            end
            S_SP3: begin
               // stop done: data rises with clock high, flag stays low
               if (tick && scl_s) begin
                  sda_low_d = 1'b0;
                  sto_clr   = 1'b1;
                  mr_d      = 1'b0;
                  mt_d      = 1'b0;
                  state_d   = ctrl_q.start_request ? S_WFREE : S_IDLE;
               end
            end
            S_RS1: begin
               if (tick) begin
                  sda_low_d = 1'b0;
                  state_d   = S_RS2;
               end
            end
            S_RS2: begin
               if (tick) begin
                  scl_low_d = 1'b0;
                  state_d   = S_RS3;
               end
            end
            S_RS3: begin
               if (tick && scl_s) begin
                  sda_low_d = 1'b1;
                  rs_d      = 1'b1;
                  state_d   = S_ST1;
               end
            end
            S_LOST: begin
               // bus released; wait for software, then idle or retry
               scl_low_d = 1'b0;
               sda_low_d = 1'b0;
               if (!ctrl_q.flag) state_d = ctrl_q.start_request ? S_WFREE : S_IDLE;
            end
            default: begin
               state_d = S_IDLE;
            end
         endcase
      end
   end

   // checks
   property p_stretch;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == S_HOLD && ctrl_q.flag) |=> scl_oe;
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock not held low");

   property p_start_code;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == S_ST2 && tick && !rs_q && ctrl_q.en) |=> ctrl_q.flag && status_q == 8'h08;
   endproperty
   a_start_code: assert property (p_start_code) else $error("start code wrong");

   property p_rstart;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == S_RS3 && tick && scl_s && ctrl_q.en && !wr_ctrl)
         |-> ##[1:600] (ctrl_q.flag && status_q == 8'h10);
   endproperty
   a_rstart: assert property (p_rstart) else $error("repeated start code");

   property p_no_flag_stop;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == S_SP3 && tick && scl_s) |=> !$rose(ctrl_q.flag) ##1 !$rose(ctrl_q.flag);
   endproperty
   a_no_flag_stop: assert property (p_no_flag_stop) else $error("flag after stop");

   property p_sto_clear;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == S_SP3 && tick && scl_s && ctrl_q.en && !wr_ctrl) |=> !ctrl_q.stop_request;
   endproperty
   a_sto_clear: assert property (p_sto_clear) else $error("stop bit not cleared");

   property p_discard;
      @(posedge ref_clk) disable iff (sys_rst)
      (wr_data && !ctrl_q.flag) |=> (data_q == $past(data_q));
   endproperty
   a_discard: assert property (p_discard) else $error("data write not discarded");

   property p_status_hold;
      @(posedge ref_clk) disable iff (sys_rst)
      (ctrl_q.flag && $past(ctrl_q.flag)) |-> $stable(status_q);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status moved");

   property p_data_ack;
      @(posedge ref_clk) disable iff (sys_rst)
      (bit_done && ctrl_q.en && bits_q == BYTE_BITS && !addr_q)
         |=> (status_q == ($past(ack_seen) ? 8'h28 : 8'h30)) || !ctrl_q.en;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data ack code");

   property p_addr_ack;
      @(posedge ref_clk) disable iff (sys_rst)
      (bit_done && ctrl_q.en && bits_q == BYTE_BITS && addr_q && !mr_q && sda_s)
         ##1 ctrl_q.en [*2] |=> status_q == 8'h20;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address nack code");

   property p_arb;
      @(posedge ref_clk) disable iff (sys_rst)
      (arb_lost && ctrl_q.en) |=> status_q == 8'h38 && !scl_oe && !sda_oe;
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration loss handling");
endmodule

/* inc/twm_pkg.sv */
// shared constants and types for the two-wire master transmitter
package twm_pkg;
   typedef logic [1:0] twm_addr_t;              // register index
   typedef logic [7:0] twm_byte_t;              // one bus byte
   // register indices on the plain register port
   localparam twm_addr_t ADDR_CTRL = 2'h0;      // serial_bus_control
   localparam twm_addr_t ADDR_DATA = 2'h1;      // serial_bus_data
   localparam twm_addr_t ADDR_STAT = 2'h2;      // serial_bus_status
   localparam twm_addr_t ADDR_RATE = 2'h3;      // quarter-bit divider
   // control bit positions
   localparam int unsigned CB_EN   = 6;         // unit_enable
   localparam int unsigned CB_STA  = 5;         // start_request
   localparam int unsigned CB_STO  = 4;         // stop_request
   localparam int unsigned CB_FLAG = 3;         // step_done_flag
   localparam int unsigned CB_ACK  = 2;         // ack_enable
   // status codes
   localparam twm_byte_t ST_START   = 8'h08;    // start sent
   localparam twm_byte_t ST_RSTART  = 8'h10;    // repeated start sent
   localparam twm_byte_t ST_AW_ACK  = 8'h18;    // write address acked
   localparam twm_byte_t ST_AW_NACK = 8'h20;    // write address not acked
   localparam twm_byte_t ST_D_ACK   = 8'h28;    // data acked
   localparam twm_byte_t ST_D_NACK  = 8'h30;    // data not acked
   localparam twm_byte_t ST_ARB     = 8'h38;    // arbitration lost
   localparam twm_byte_t ST_AR_ACK  = 8'h40;    // read address acked
   localparam twm_byte_t ST_AR_NACK = 8'h48;    // read address not acked
   localparam twm_byte_t ST_NONE    = 8'hF8;    // no valid code
   // reset values and counts
   localparam twm_byte_t RST_RATE  = 8'h01;     // quarter bit = 2 clocks
   localparam twm_byte_t RST_DATA  = 8'hFF;     // data register
   localparam logic [3:0] BYTE_BITS = 4'h8;     // bits per byte
   // control register fields
   typedef struct packed {
      logic en;                                 // unit_enable
      logic start_request;                                // start_request
      logic stop_request;                                // stop_request
      logic flag;                               // step_done_flag
      logic ack;                                // ack_enable, stored only
   } twm_ctrl_s;
   localparam twm_ctrl_s RST_CTRL = '0;         // all clear after reset
   // sequencer states
   typedef enum logic [3:0] {
      S_IDLE  = 4'h0, S_WFREE = 4'h1, S_ST1 = 4'h2, S_ST2 = 4'h3,
      S_HOLD  = 4'h4, S_BLOW  = 4'h5, S_BSET = 4'h6, S_BHIGH = 4'h7,
      S_AEND  = 4'h8, S_SP1   = 4'h9, S_SP2 = 4'hA, S_SP3 = 4'hB,
      S_RS1   = 4'hC, S_RS2   = 4'hD, S_RS3 = 4'hE, S_LOST = 4'hF
   } twm_state_e;
endpackage

/* testbench/twm_slave_model.sv */
// behavioural slave receiver on the two-wire bus, with stretch and bus grab
`timescale 1ns/10ps
module twm_slave_model (
   input  wire logic       scl,       // resolved clock line
   input  wire logic       sda,       // resolved data line
   input  wire logic       ack_en,    // acknowledge each byte
   input  wire logic       stretch,   // hold clock low after each fall
   input  wire logic       grab,      // rival master pulls data low
   output logic            scl_pull,  // pull clock line low
   output logic            sda_pull,  // pull data line low
   output logic [7:0]      last_byte, // last byte taken in
   output int              n_stop     // stops seen
);
   logic [7:0] sh;       // shift register, msb first
   int         bitcnt;   // bit position in frame
   logic       in_frame; // between start and stop
   logic       ack_pull; // acknowledge drive
   initial begin
      {scl_pull, ack_pull, in_frame, sh, last_byte} = '0;
      bitcnt = 0;
      n_stop = 0;
   end
   // rival only pulls in bit slots; dropping grab while the clock is high gives a stop
   assign sda_pull = ack_pull | (grab & in_frame & (bitcnt < 8));
   // start and stop are data edges while clock high
   always @(negedge sda) if (scl) begin
      in_frame = 1'b1;
      bitcnt = 0;
   end
   always @(posedge sda) if (scl) begin
      in_frame = 1'b0;
      n_stop++;
   end
   // msb first, sampled on rising clock
   always @(posedge scl) if (in_frame) begin
      if (bitcnt < 8) sh = {sh[6:0], sda};
      bitcnt++;
   end
   // ack is a low level in the ninth slot, nack leaves it high
   always @(negedge scl) begin
      if (bitcnt == 8) ack_pull = ack_en;
      else if (bitcnt == 9) begin
         ack_pull = 1'b0;
         bitcnt = 0;
         last_byte = sh;
      end
   end
   // slow slave: clock held low 400 ns after each fall
   always @(negedge scl) if (stretch) begin
      scl_pull = 1'b1;
      #400 scl_pull = 1'b0;
   end
endmodule

/* testbench/twm_master_tx_test.sv */
// self-checking bench for the two-wire master transmitter
`timescale 1ns/10ps
module twm_master_tx_test;
   import twm_pkg::*;
   logic       ref_clk, sys_rst, reg_wr, reg_rd;    // clock, reset, strobes
   twm_addr_t  reg_addr;                            // register index
   twm_byte_t  reg_wdata, reg_rdata, last_byte, rv; // bus data
   logic       scl_oe, sda_oe, m_scl, m_sda;        // line pulls
   logic       scl_o, sda_o;                        // open-drain drive values
   logic       mtx, mrx, flag, ack_en, stretch, grab; // status and model knobs
   int         n_stop, n, n_mismatch, tests_run;    // counters
   // open drain lines with pull-ups
   wire scl_w = ~(scl_oe | m_scl);
   wire sda_w = ~(sda_oe | m_sda);
   twm_master_tx dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_o),
      .sda_oe(sda_oe), .master_transmit_mode(mtx), .master_receive_mode(mrx),
      .step_done_flag(flag));
   twm_slave_model slave (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .stretch(stretch),
      .grab(grab), .scl_pull(m_scl), .sda_pull(m_sda), .last_byte(last_byte),
      .n_stop(n_stop));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic chk(input twm_byte_t seen, input twm_byte_t exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input twm_addr_t a, input twm_byte_t d);
      @(posedge ref_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand from the cycle after the strobe until the next read
   task automatic rd(input twm_addr_t a, output twm_byte_t d);
      @(posedge ref_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // clear the flag with a control value, wait bounded for the next flag
   task automatic step(input twm_byte_t c, input twm_byte_t exp);
      wr(ADDR_CTRL, c);
      repeat (3000) begin
         @(negedge ref_clk);
         if (flag === 1'b1) break;
      end
      rd(ADDR_STAT, rv);
      chk(rv, exp);
   endtask
   task automatic t_reset;
      rd(ADDR_CTRL, rv);
      chk(rv, 8'h00);
      rd(ADDR_DATA, rv);
      chk(rv, RST_DATA);
      rd(ADDR_STAT, rv);
      chk(rv, ST_NONE);
      rd(ADDR_RATE, rv);
      chk(rv, RST_RATE);
      $display("test reset done");
   endtask
   task automatic t_start_addr;
      wr(ADDR_DATA, 8'h55);          // dropped: flag low
      step(8'h60, ST_START);
      rd(ADDR_DATA, rv);
      chk(rv, RST_DATA);
      chk({7'h0, scl_oe}, 8'h01);
      chk({6'h0, scl_o, sda_o}, 8'h00);
      wr(ADDR_DATA, 8'hA0);
      step(8'h40, ST_AW_ACK);
      chk(last_byte, 8'hA0);
      chk({7'h0, mtx}, 8'h01);
      $display("test start_addr done");
   endtask
   task automatic t_data;
      ack_en <= 1'b0;
      wr(ADDR_DATA, 8'h3C);
      step(8'h44, ST_D_NACK);
      chk(last_byte, 8'h3C);
      {ack_en, stretch} <= 2'b11;
      wr(ADDR_DATA, 8'hC3);
      step(8'h40, ST_D_ACK);
      stretch <= 1'b0;
      $display("test data done");
   endtask
   task automatic t_stop_start;
      n = n_stop;
      step(8'h70, ST_START);
      chk(8'(n_stop - n), 8'h01);
      rd(ADDR_CTRL, rv);
      chk(rv & 8'h10, 8'h00);
      ack_en <= 1'b0;                // slave refuses this address
      wr(ADDR_DATA, 8'hA0);
      step(8'h40, ST_AW_NACK);
      ack_en <= 1'b1;
      $display("test stop_start done");
   endtask
   task automatic t_rstart;
      n = n_stop;
      step(8'h60, ST_RSTART);
      chk(8'(n_stop - n), 8'h00);
      wr(ADDR_DATA, 8'hA1);
      step(8'h40, ST_AR_ACK);
      chk({6'h0, mrx, mtx}, 8'h02);
      $display("test rstart done");
   endtask
   task automatic t_arb;
      for (int i = 0; i < 2; i++) begin
         // first pass leaves receive mode, so the start is a repeat
         step(8'h60, (i == 0) ? ST_RSTART : ST_START);
         grab <= 1'b1;
         wr(ADDR_DATA, 8'hFF);
         step(8'h40, ST_ARB);
         chk({6'h0, scl_oe, sda_oe}, 8'h00);
         grab <= 1'b0;
         if (i == 0) begin
            wr(ADDR_CTRL, 8'h40);
            repeat (40) @(negedge ref_clk);
            chk({6'h0, flag, scl_oe}, 8'h00);
         end else step(8'h60, ST_START);
      end
      wr(ADDR_DATA, 8'hA0);
      step(8'h40, ST_AW_ACK);
      $display("test arb done");
   endtask
   task automatic t_stop;
      n = n_stop;
      wr(ADDR_CTRL, 8'h50);
      repeat (400) @(negedge ref_clk);
      chk(8'(n_stop - n), 8'h01);
      chk({6'h0, flag, scl_oe}, 8'h00);
      rd(ADDR_CTRL, rv);
      chk(rv & 8'h10, 8'h00);
      $display("test stop done");
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // a hang counts as a mismatch
   initial begin
      #2000000;
      n_mismatch++;
      final_report;
   end
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, stretch, grab} = '0;
      {sys_rst, ack_en} = 2'b11;
      n_mismatch = 0;
      tests_run = 0;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      t_reset;
      t_start_addr;
      t_data;
      t_stop_start;
      t_rstart;
      t_arb;
      t_stop;
      final_report;
   end
endmodule
